//--- hw/ramdac_defs.svh
// Register offsets, field positions and reset values of the host register port
`ifndef RAMDAC_DEFS_SVH
`define RAMDAC_DEFS_SVH

// Register select codes
`define REG_ADDR     2'h0
`define REG_DATA     2'h1
`define REG_MODE     2'h2
`define REG_SYNTH    2'h3
// Reset value of every host register
`define RST_VAL      8'h00
// Mode register fields
`define MODE_PSEUDO  4'h0
`define MODE_PACKED  4'hE
`define SIX_POS      4
// Synthesizer control register fields
`define SW_A_POS     7
`define SW_B_POS     3
`define SEL_A_LSB    4
`define SEL_B_LSB    0
// Half-period divisors of the synthesizer register sets
`define DIV_A0       8'h01
`define DIV_A1       8'h02
`define DIV_A2       8'h03
`define DIV_A3       8'h04
`define DIV_B0       8'h05
`define DIV_B1       8'h06
`define DIV_B2       8'h07
`define DIV_B3       8'h08
`endif

//--- hw/ramdac_pkg.sv
// Types shared by the pixel and host port modules
`default_nettype none
package ramdac_pkg;
    // Host strobe sequencer states
    typedef enum logic [1:0] {HP_IDLE, HP_READ, HP_WRITE} host_state_t;

    // One word of the pixel stream
    typedef struct packed {
        logic        first;   // First pixel after blanking
        logic        blank_n; // Low while blanked
        logic [23:0] color;   // Colour value
    } pix_word_t;

    // Host clock domain state
    typedef struct packed {
        logic             rd1, rd2, rd3;   // Read strobe sync
        logic             wr1, wr2, wr3;   // Write strobe sync
        logic [1:0]       rs1, rs2;        // Select sync
        logic [7:0]       d1, d2;          // Data sync
        logic [1:0]       fs1, fs2;        // Frequency pin sync
        host_state_t      st;              // Strobe sequencer
        logic [1:0]       rs;              // Select caught on fall
        logic             oe_n;            // Bus output enable
        logic [7:0]       dout;            // Read data
        logic [7:0]       addr;            // Lookup index register
        logic [7:0]       mode;            // Mode register
        logic [7:0]       ctrl;            // Synthesizer control
        logic [15:0][7:0] lut;             // Colour lookup memory
        logic [1:0]       sel_a, sel_b;    // Active register sets
        logic [7:0]       cnt_a, cnt_b;    // Divider counters
        logic             ck_a, ck_b;      // Synthesized clocks
    } sys_state_t;

    // Pixel clock domain state
    typedef struct packed {
        logic        rst1, rst2;   // Reset sync
        logic [7:0]  m1, m2;       // Mode crossing
        logic        b1, b2, b3;   // Blank capture chain
        logic [15:0] p1, p2;       // Pixel capture chain
        logic        phase;        // Packed mode half
        logic [15:0] hold;         // Packed mode low half
        logic        first_pend;   // First flag awaiting push
        logic        wr_valid;     // Push to FIFO
        pix_word_t   wr_data;      // Word pushed
        logic        out_valid;    // Output stage full
        pix_word_t   out;          // Output stage word
    } pix_state_t;
endpackage
`default_nettype wire

//--- hw/pix_fifo_if.sv
// Valid/ready carrier between the pixel pipeline and its FIFO
`timescale 1ns/1ns
`default_nettype none
interface pix_fifo_if #(parameter int W = 26);
    logic         wr_valid;  // Word offered
    logic         wr_ready;  // FIFO has room
    logic [W-1:0] wr_data;   // Word in
    logic         rd_valid;  // Word available
    logic         rd_ready;  // Drain accepts
    logic [W-1:0] rd_data;   // Word out
    modport src  (output wr_valid, wr_data, input wr_ready,
                  input rd_valid, rd_data, output rd_ready);
    modport fifo (input wr_valid, wr_data, rd_ready,
                  output wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

//--- hw/pix_fifo.sv
// Synchronous FIFO with registered write ready
`timescale 1ns/1ns
`default_nettype none
module pix_fifo #(
    parameter int W     = 26,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Both sides
    pix_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);

    // ==========================================================
    // State
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;    // Storage
        logic [AW:0]             wp;     // Write pointer
        logic [AW:0]             rp;     // Read pointer
        logic                    full_n; // Registered room flag
    } fifo_t;

    localparam fifo_t RST_Q = '{mem: '0, wp: '0, rp: '0, full_n: 1'b1};

    fifo_t q_r;   // Current state
    fifo_t q_nxt; // Next state

    // Read side straight from the pointers
    assign f.rd_valid = (q_r.wp != q_r.rp);
    assign f.rd_data  = q_r.mem[q_r.rp[AW-1:0]];
    assign f.wr_ready = q_r.full_n;

    // ==========================================================
    // Next state
    always_comb begin
        q_nxt = q_r;
        // Push only while room is flagged
        if (f.wr_valid && q_r.full_n) begin
            q_nxt.mem[q_r.wp[AW-1:0]] = f.wr_data;
            q_nxt.wp = q_r.wp + 1'b1;
        end
        // Pop when the drain takes it
        if (f.rd_ready && f.rd_valid) begin
            q_nxt.rp = q_r.rp + 1'b1;
        end
        // Ready computed ahead so it is a flop, yet exact
        q_nxt.full_n = ((q_nxt.wp - q_nxt.rp) != (AW+1)'(DEPTH));
    end

    // Register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r <= RST_Q;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Never push beyond depth
    depth_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
        (q_r.wp - q_r.rp) <= (AW+1)'(DEPTH))
        else $error("fifo holds more words than its depth");
endmodule
`default_nettype wire

//--- hw/ramdac_port.sv
// Host register port, pixel latch and synthesizer clock outputs
`timescale 1ns/1ns
`default_nettype none
`include "ramdac_defs.svh"
module ramdac_port #(
    parameter int FIFO_DEPTH = 8
) (
    // System clock and reset
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST_N,
    // Host port
    input  wire logic                 RD_N,
    input  wire logic                 WR_N,
    input  wire logic [1:0]           REGISTER_SELECT_LINES,
    input  wire logic [7:0]           D_IN,
    output var  logic [7:0]           D_OUT,
    output var  logic                 D_OE_N,
    // Synthesizer
    input  wire logic [1:0]           FREQ_SET_SELECT_PINS,
    output var  logic                 SYNTH_CLOCK_OUT_FIRST,
    output var  logic                 SYNTH_CLOCK_OUT_SECOND,
    // Pixel side
    input  wire logic                 PIX_CLK,
    input  wire logic                 BLANK_N,
    input  wire logic [15:0]          PIX,
    output var  logic                 PIX_ACCEPT,
    // Converter side
    input  wire logic                 DAC_READY,
    output var  logic                 COLOR_VALID,
    output var  ramdac_pkg::pix_word_t COLOR_WORD
);
    import ramdac_pkg::*;

    // ==========================================================
    // Host domain
    sys_state_t s_r;   // Current state
    sys_state_t s_nxt; // Next state

    // Idle strobes high, bus released, sets from pins
    localparam sys_state_t S_RST = '{rd1: 1'b1, rd2: 1'b1, rd3: 1'b1,
        wr1: 1'b1, wr2: 1'b1, wr3: 1'b1, st: HP_IDLE, oe_n: 1'b1,
        addr: `RST_VAL, mode: `RST_VAL, ctrl: `RST_VAL, default: '0};

    logic rd_fall, rd_rise, wr_fall, wr_rise; // Strobe edges
    logic six;                                // Six-bit colour

    // Edges read only the second and third flops
    assign rd_fall = s_r.rd3 && !s_r.rd2;
    assign rd_rise = !s_r.rd3 && s_r.rd2;
    assign wr_fall = s_r.wr3 && !s_r.wr2;
    assign wr_rise = !s_r.wr3 && s_r.wr2;
    assign six     = s_r.mode[`SIX_POS];

    // Read multiplexer, used at the strobe fall and while held
    function automatic logic [7:0] rd_mux(input sys_state_t s,
                                          input logic [1:0] sel);
        logic [7:0] v;
        v = s.addr;
        case (sel)
            `REG_ADDR:  v = s.addr;
            `REG_DATA:  v = s.lut[s.addr[3:0]];
            `REG_MODE:  v = s.mode;
            default:    v = s.ctrl;
        endcase
        // Upper lines read low in six-bit operation
        if (s.mode[`SIX_POS]) begin
            v[7:6] = 2'b00;
        end
        return v;
    endfunction

    // Divisor of a synthesizer register set
    function automatic logic [7:0] div_of(input logic second,
                                          input logic [1:0] set);
        logic [7:0] d;
        d = `DIV_A0;
        case ({second, set})
            3'h0:    d = `DIV_A0;
            3'h1:    d = `DIV_A1;
            3'h2:    d = `DIV_A2;
            3'h3:    d = `DIV_A3;
            3'h4:    d = `DIV_B0;
            3'h5:    d = `DIV_B1;
            3'h6:    d = `DIV_B2;
            default: d = `DIV_B3;
        endcase
        return d;
    endfunction

    // Host next state
    always_comb begin
        s_nxt = s_r;
        // Two-flop synchronisers on every host pin
        s_nxt.rd1 = RD_N;
        s_nxt.rd2 = s_r.rd1;
        s_nxt.rd3 = s_r.rd2;
        s_nxt.wr1 = WR_N;
        s_nxt.wr2 = s_r.wr1;
        s_nxt.wr3 = s_r.wr2;
        s_nxt.rs1 = REGISTER_SELECT_LINES;
        s_nxt.rs2 = s_r.rs1;
        s_nxt.d1  = D_IN;
        s_nxt.d2  = s_r.d1;
        s_nxt.fs1 = FREQ_SET_SELECT_PINS;
        s_nxt.fs2 = s_r.fs1;
        case (s_r.st)
            HP_IDLE: begin
                // Select caught on either strobe fall
                if (rd_fall) begin
                    s_nxt.rs   = s_r.rs2;
                    s_nxt.dout = rd_mux(s_r, s_r.rs2);
                    s_nxt.oe_n = 1'b0;
                    s_nxt.st   = HP_READ;
                end else if (wr_fall) begin
                    s_nxt.rs = s_r.rs2;
                    s_nxt.st = HP_WRITE;
                end
            end
            HP_READ: begin
                // Keep driving until the strobe returns high
                s_nxt.dout = rd_mux(s_r, s_r.rs);
                if (rd_rise) begin
                    s_nxt.oe_n = 1'b1;
                    s_nxt.st   = HP_IDLE;
                end
            end
            HP_WRITE: begin
                // Data taken as the write strobe rises
                if (wr_rise) begin
                    s_nxt.st = HP_IDLE;
                    case (s_r.rs)
                        `REG_ADDR: s_nxt.addr = s_r.d2;
                        `REG_DATA: begin
                            // Six-bit mode keeps only the low six colour bits
                            s_nxt.lut[s_r.addr[3:0]] = six ?
                                {2'b00, s_r.d2[5:0]} : s_r.d2;
                            s_nxt.addr = s_r.addr + 8'h01;
                        end
                        `REG_MODE: s_nxt.mode = s_r.d2;
                        default:   s_nxt.ctrl = s_r.d2;
                    endcase
                end
            end
            default: s_nxt.st = HP_IDLE;
        endcase
        // Per synthesizer, its control bit picks pins or fields
        s_nxt.sel_a = s_r.ctrl[`SW_A_POS] ?
            s_r.ctrl[`SEL_A_LSB+:2] : s_r.fs2;
        s_nxt.sel_b = s_r.ctrl[`SW_B_POS] ?
            s_r.ctrl[`SEL_B_LSB+:2] : s_r.fs2;
        // Dividers; >= guards against a shrinking divisor
        if (s_r.cnt_a >= div_of(1'b0, s_r.sel_a) - 8'h01) begin
            s_nxt.cnt_a = 8'h00;
            s_nxt.ck_a  = !s_r.ck_a;
        end else begin
            s_nxt.cnt_a = s_r.cnt_a + 8'h01;
        end
        if (s_r.cnt_b >= div_of(1'b1, s_r.sel_b) - 8'h01) begin
            s_nxt.cnt_b = 8'h00;
            s_nxt.ck_b  = !s_r.ck_b;
        end else begin
            s_nxt.cnt_b = s_r.cnt_b + 8'h01;
        end
    end

    // Host register; reset clears registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Host pins and clock pins straight from flops
    assign D_OUT                  = s_r.dout;
    assign D_OE_N                 = s_r.oe_n;
    assign SYNTH_CLOCK_OUT_FIRST  = s_r.ck_a;
    assign SYNTH_CLOCK_OUT_SECOND = s_r.ck_b;

    // ==========================================================
    // Pixel domain
    pix_state_t p_r;   // Current state
    pix_state_t p_nxt; // Next state

    pix_fifo_if #(.W($bits(pix_word_t))) f ();

    // Pixel pipeline next state
    always_comb begin
        pix_word_t w;
        logic      push;
        w    = '0;
        push = 1'b1;
        p_nxt = p_r;
        // Reset and mode cross as levels over two flops
        p_nxt.rst1 = RST_N;
        p_nxt.rst2 = p_r.rst1;
        p_nxt.m1   = s_r.mode;
        p_nxt.m2   = p_r.m1;
        // Blank and pixels latched together
        p_nxt.b1 = BLANK_N;
        p_nxt.b2 = p_r.b1;
        p_nxt.b3 = p_r.b2;
        p_nxt.p1 = PIX;
        p_nxt.p2 = p_r.p1;
        w.blank_n = p_r.b2;
        if (!p_r.b2) begin
            // Pixels ignored, colour forced to zero
            p_nxt.phase      = 1'b0;
            p_nxt.first_pend = 1'b0;
        end else begin
            w.first = p_r.b2 && !p_r.b3;
            case (p_r.m2[3:0])
                `MODE_PSEUDO: begin
                    // Pixel used as lookup index
                    w.color = {3{s_r.lut[p_r.p2[3:0]]}};
                end
                `MODE_PACKED: begin
                    // Half one aligns to blank rise
                    if (!p_r.phase) begin
                        p_nxt.hold       = p_r.p2;
                        p_nxt.first_pend = w.first;
                        p_nxt.phase      = 1'b1;
                        push             = 1'b0;
                    end else begin
                        w.color          = {p_r.p2[7:0], p_r.hold};
                        w.first          = p_r.first_pend;
                        p_nxt.first_pend = 1'b0;
                        p_nxt.phase      = 1'b0;
                    end
                end
                default: begin
                    // True colour passes straight
                    w.color = {p_r.p2[15:11], 3'h0, p_r.p2[10:5], 2'h0,
                               p_r.p2[4:0], 3'h0};
                end
            endcase
        end
        p_nxt.wr_valid = push;
        p_nxt.wr_data  = w;
        // Output stage; drains FIFO when the stage is empty or the converter is ready
        if (f.rd_valid && f.rd_ready) begin
            p_nxt.out_valid = 1'b1;
            p_nxt.out       = pix_word_t'(f.rd_data);
        end else if (DAC_READY) begin
            p_nxt.out_valid = 1'b0;
        end
        // Control state cleared while reset is held
        if (!p_r.rst2) begin
            p_nxt.phase      = 1'b0;
            p_nxt.first_pend = 1'b0;
            p_nxt.wr_valid   = 1'b0;
            p_nxt.out_valid  = 1'b0;
            p_nxt.out        = '0;
        end
    end

    // Pixel register
    always_ff @(posedge PIX_CLK) begin
        p_r <= p_nxt;
    end

    // FIFO wiring; a full FIFO drops pixels, shown on PIX_ACCEPT
    assign f.wr_valid = p_r.wr_valid;
    assign f.wr_data  = p_r.wr_data;
    assign f.rd_ready = !p_r.out_valid || DAC_READY;

    pix_fifo #(.W($bits(pix_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk   (PIX_CLK),
        .rst_n (p_r.rst2),
        .f     (f.fifo)
    );

    assign PIX_ACCEPT  = f.wr_ready;
    assign COLOR_VALID = p_r.out_valid;
    assign COLOR_WORD  = p_r.out;

    // ==========================================================
    // Assertions
    capture_a: assert property (@(posedge PIX_CLK) disable iff (!p_r.rst2)
        1'b1 |=> ##1 (p_r.b2 == $past(BLANK_N, 2) &&
                      p_r.p2 == $past(PIX, 2)))
        else $error("pixel or blank not latched in two edges");
    blank_force_a: assert property (@(posedge PIX_CLK) disable iff (!p_r.rst2)
        p_r.rst2 && !p_r.b2 |=> p_r.wr_valid && !p_r.wr_data.blank_n &&
                    p_r.wr_data.color == 24'h000000)
        else $error("blanked pixel not forced to zero");
    first_align_a: assert property (@(posedge PIX_CLK) disable iff (!p_r.rst2)
        p_r.rst2 && $rose(p_r.b2) && p_r.m2[3:0] == `MODE_PACKED
        && $stable(p_r.m2) |=> ##1 p_r.wr_valid && p_r.wr_data.first)
        else $error("packed first pixel misaligned");
    out_pair_a: assert property (@(posedge PIX_CLK) disable iff (!p_r.rst2)
        f.rd_valid && f.rd_ready |=> p_r.out == $past(f.rd_data))
        else $error("output stage lost its word");
    read_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        rd_fall && s_r.st == HP_IDLE
        |=> !D_OE_N && s_r.rs == $past(s_r.rs2))
        else $error("read not driven on strobe fall");
    read_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !D_OE_N && !s_r.rd2 |=> !D_OE_N)
        else $error("bus released while read strobe low");
    read_end_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        rd_rise && s_r.st == HP_READ |=> D_OE_N && s_r.st == HP_IDLE)
        else $error("bus not released after read");
    six_read_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !D_OE_N && six |-> D_OUT[7:6] == 2'b00)
        else $error("upper data bits driven in six-bit mode");
    six_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_rise && s_r.st == HP_WRITE && s_r.rs == `REG_DATA && six
        |=> s_r.lut[$past(s_r.addr[3:0])] == {2'b00, $past(s_r.d2[5:0])})
        else $error("colour write kept upper bits");
    sel_pins_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !s_r.ctrl[`SW_A_POS] && !s_r.ctrl[`SW_B_POS]
        |=> s_r.sel_a == $past(s_r.fs2) && s_r.sel_b == $past(s_r.fs2))
        else $error("pins do not pick register set");
    sel_reg_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_r.ctrl[`SW_A_POS] && s_r.ctrl[`SW_B_POS]
        |=> s_r.sel_a == $past(s_r.ctrl[`SEL_A_LSB+:2]) &&
            s_r.sel_b == $past(s_r.ctrl[`SEL_B_LSB+:2]))
        else $error("control fields do not pick register set");
    reset_clear_a: assert property (@(posedge CLK_SYS)
        !RST_N |=> s_r.mode == `RST_VAL && s_r.ctrl == `RST_VAL && D_OE_N)
        else $error("reset left registers set");

    read_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        rd_fall ##[1:20] rd_rise);
    write_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_rise && s_r.st == HP_WRITE);
    packed_c: cover property (@(posedge PIX_CLK) disable iff (!p_r.rst2)
        p_r.wr_valid && p_r.wr_data.first && p_r.m2[3:0] == `MODE_PACKED);
endmodule
`default_nettype wire

//--- tb/host_model.sv
// Host processor model: strobe cycles and the shared data bus wire
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Clock
    input  wire logic       clk,
    // Device side of the bus
    input  wire logic [7:0] d_out,
    input  wire logic       d_oe_n,
    // Host strobes and wire level
    output var  logic       rd_n,
    output var  logic       wr_n,
    output var  logic [1:0] sel,
    output wire logic [7:0] d_in
);
    logic       drv;  // Host drives the bus
    logic [7:0] hdat; // Host data
    logic [7:0] last; // Last wire level
    // ====================
    // Bus wire
    // Floating bus inverts each cycle so stale data never passes
    assign d_in = drv ? hdat : (!d_oe_n ? d_out : ~last);
    always @(posedge clk) last <= d_in;
    initial begin
        {rd_n, wr_n, sel, drv, hdat, last} = {2'h3, 2'h0, 1'b0, 16'h0};
    end
    // ====================
    // Write cycle, data held well past the strobe rise
    task automatic put(input logic [1:0] s, input logic [7:0] v);
        @(posedge clk);
        {wr_n, sel, hdat, drv} <= {1'b0, s, v, 1'b1};
        repeat (5) @(posedge clk);
        wr_n <= 1'b1;
        repeat (5) @(posedge clk);
        drv <= 1'b0;
    endtask
    // Read cycle, strobe held low until data is taken
    task automatic get(input logic [1:0] s, output logic [7:0] v,
                       output logic oe_low, output logic oe_rel);
        @(posedge clk);
        {rd_n, sel} <= {1'b0, s};
        repeat (6) @(posedge clk);
        v = d_in;
        oe_low = d_oe_n;
        rd_n <= 1'b1;
        repeat (6) @(posedge clk);
        oe_rel = d_oe_n;
    endtask
endmodule
`default_nettype wire

//--- tb/ramdac_port_tb.sv
// Self-checking bench for the host port, synthesizer and pixel path
`timescale 1ns/1ns
`default_nettype none
module ramdac_port_tb;
    import ramdac_pkg::*;
    logic        clk_sys, pix_clk, rst_n, dac_ready, blank_n;
    logic [1:0]  fs;      // Frequency pins
    logic [15:0] pix;     // Pixel bus
    logic        rd_n, wr_n, d_oe_n, accept, cvalid;
    logic [1:0]  sel, cks; // Select, synthesized clocks
    logic [7:0]  d_out, v;
    wire  [7:0]  d_in;
    logic        lo, rel;  // Enable during and after a read
    pix_word_t   cword;
    int          err_count, checks, cyc, n;
    initial begin
        // Converter ready and display live while reset is held
        {clk_sys, rst_n, dac_ready, blank_n, fs, pix} = {4'h3, 2'h2, 16'h0};
        forever #10 clk_sys = ~clk_sys;
    end
    // Link clock, unrelated phase
    initial begin
        pix_clk = 1'b0;
        #2;
        forever #3 pix_clk = ~pix_clk;
    end
    host_model host_model_inst (.clk(clk_sys), .d_out(d_out),
        .d_oe_n(d_oe_n), .rd_n(rd_n), .wr_n(wr_n), .sel(sel), .d_in(d_in));
    ramdac_port #(.FIFO_DEPTH(8)) ramdac_port_inst (.CLK_SYS(clk_sys),
        .RST_N(rst_n), .RD_N(rd_n), .WR_N(wr_n),
        .REGISTER_SELECT_LINES(sel), .D_IN(d_in), .D_OUT(d_out),
        .D_OE_N(d_oe_n), .FREQ_SET_SELECT_PINS(fs),
        .SYNTH_CLOCK_OUT_FIRST(cks[0]), .SYNTH_CLOCK_OUT_SECOND(cks[1]),
        .PIX_CLK(pix_clk), .BLANK_N(blank_n), .PIX(pix),
        .PIX_ACCEPT(accept), .DAC_READY(dac_ready),
        .COLOR_VALID(cvalid), .COLOR_WORD(cword));
    // ====================
    // Shared tasks
    task automatic chk(input string nm, input logic [25:0] e,
                       input logic [25:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Half period of one synthesized clock, in system cycles
    task automatic half(input int w);
        logic p;
        p = cks[w];
        for (int i = 0; i < 300 && cks[w] === p; i++) @(posedge clk_sys);
        p = cks[w];
        n = 0;
        for (int i = 0; i < 40 && cks[w] === p; i++) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    // Drive one pixel setting, let the pipeline settle
    task automatic px(input logic b, input logic [15:0] p, input int k);
        @(posedge pix_clk);
        {blank_n, pix} <= {b, p};
        repeat (k) @(posedge pix_clk);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize;
        end
    end
    // ====================
    // Scenarios
    task automatic t_regs;
        host_model_inst.get(2'h2, v, lo, rel);
        chk("mode at reset", 8'h00, v);
        host_model_inst.put(2'h3, 8'hC0);
        host_model_inst.put(2'h2, 8'h5A); // Six-bit on
        host_model_inst.get(2'h2, v, lo, rel);
        chk("mode read", 8'h1A, v);
        chk("driving", 1'b0, lo);
        chk("released", 1'b1, rel);
        host_model_inst.get(2'h3, v, lo, rel);
        chk("synth read", 8'h00, v);
        host_model_inst.put(2'h0, 8'h05);
        host_model_inst.put(2'h1, 8'hFF);
        host_model_inst.get(2'h0, v, lo, rel);
        chk("index step", 8'h06, v);
        host_model_inst.put(2'h0, 8'h05);
        host_model_inst.put(2'h2, 8'h00); // Pseudo, eight-bit
        host_model_inst.get(2'h1, v, lo, rel);
        chk("colour entry", 8'h3F, v);
        $display("register test done");
    endtask
    task automatic t_synth;
        host_model_inst.put(2'h3, 8'h00);
        half(0);
        chk("pin set a", 26'd3, 26'(n));
        half(1);
        chk("pin set b", 26'd7, 26'(n));
        host_model_inst.put(2'h3, 8'hB8);
        half(0);
        chk("ctrl set a", 26'd4, 26'(n));
        half(1);
        chk("ctrl set b", 26'd5, 26'(n));
        $display("synthesizer test done");
    endtask
    task automatic t_pixels;
        px(1'b1, 16'hFF05, 20);
        chk("pseudo word", {1'b1, 24'h3F3F3F}, cword[24:0]);
        chk("valid", 1'b1, cvalid);
        px(1'b0, 16'hFF05, 20);
        chk("blanked", 25'h0, cword[24:0]);
        host_model_inst.put(2'h2, 8'h01); // True colour while blanked
        px(1'b1, 16'hF800, 20);
        chk("true word", {1'b1, 24'hF80000}, cword[24:0]);
        @(posedge pix_clk);
        dac_ready <= 1'b0; // Converter stalls, FIFO fills
        repeat (30) @(posedge pix_clk);
        chk("fifo full", 1'b0, accept);
        chk("word held", 1'b1, cvalid);
        dac_ready <= 1'b1;
        repeat (30) @(posedge pix_clk);
        chk("fifo drained", 1'b1, accept);
        // Packed pair: blank-rise pixel gives the low sixteen bits
        px(1'b0, 16'h0000, 4);
        host_model_inst.put(2'h2, 8'h0E);
        px(1'b0, 16'h0000, 6);
        px(1'b1, 16'h3456, 0);
        px(1'b1, 16'h0012, 0);
        for (int i = 0; i < 40 && !(cvalid && cword.first); i++)
            @(posedge pix_clk);
        chk("packed first", {2'b11, 24'h123456}, cword);
        $display("pixel test done");
    endtask
    initial begin
        fs = 2'h2;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_regs;
        t_synth;
        t_pixels;
        summarize;
    end
endmodule
`default_nettype wire
